// ==== dcbh_pkg.sv ====
// Package for the dual core bus handover block
package dcbh_pkg;

  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [7:0] DCBH_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] DCBH_STATUS_ADDR = 8'h04;
  localparam logic [7:0] DCBH_COUNT_ADDR  = 8'h08;

  // ==========================================================
  // Field positions and reset values
  localparam int         DCBH_CTRL_EN_BIT  = 0;
  localparam logic [0:0] DCBH_CTRL_RST     = 1'h1;
  localparam int         DCBH_ST_SEL_BIT   = 0;
  localparam int         DCBH_ST_SECONDARY_RESET_OUT_BIT  = 1;
  localparam int         DCBH_ST_WAIT_BIT  = 2;
  localparam int         DCBH_ST_PFLT_BIT  = 3;
  localparam int         DCBH_ST_SFLT_BIT  = 4;
  localparam int         DCBH_ST_ARM_BIT   = 5;
  localparam int         DCBH_ST_REL_BIT   = 6;

  // ==========================================================
  // Handover trigger addresses
  localparam logic [7:0]  DCBH_PRI_PORT  = 8'h38;
  localparam logic [15:0] DCBH_SEC_STORE = 16'hA038;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_PRI,
    ST_PRI_FLT,
    ST_SEC,
    ST_SEC_FLT
  } dcbh_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        memory_request_strobe_n;
    logic        io_request_strobe_n;
    logic        rd_n;
    logic        wr_n;
  } dcbh_pri_bus_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        mem_en;
    logic        io_en;
    logic        out_drive;
    logic        rw;
  } dcbh_sec_bus_t;

  typedef struct packed {
    dcbh_pri_bus_t bus;
    logic          oe;
  } dcbh_sys_bus_t;

  localparam dcbh_sys_bus_t DCBH_SYS_IDLE = '{bus: '{addr: 16'h0000, data: 8'h00,
                                                      memory_request_strobe_n: 1'b1, io_request_strobe_n: 1'b1,
                                                      rd_n: 1'b1, wr_n: 1'b1},
                                               oe: 1'b0};

endpackage

// ==== dcbh_top.sv ====
// Bus handover arbiter between a primary and a secondary processor core
`timescale 1ns/1ps

module dcbh_top
  import dcbh_pkg::*;
(
  // APB
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // External reset pin
  input  wire logic          system_reset_in,
  // Primary core
  input  wire dcbh_pri_bus_t pri_bus,
  input  wire logic          pri_halt_n,
  output logic               pri_float,
  // Secondary core
  input  wire dcbh_sec_bus_t sec_bus,
  output logic               sec_float,
  output logic               secondary_reset_out,
  output logic               secondary_wait,
  // Shared system bus
  output dcbh_sys_bus_t      sys_bus,
  output logic               core_select
);

  // ==========================================================
  // Strobe translation
  // secondary strobe mapping
  function automatic dcbh_pri_bus_t map_sec(input dcbh_sec_bus_t s);
    dcbh_pri_bus_t m;
    m.addr   = s.addr;
    m.data   = s.data;
    m.memory_request_strobe_n = ~s.mem_en;
    m.io_request_strobe_n = ~s.io_en;
    m.rd_n   = ~s.out_drive;
    m.wr_n   = s.rw;
    return m;
  endfunction

  // ==========================================================
  // Reset pin synchroniser
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= system_reset_in;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Synchroniser powers up asserted, so pin reset covers the first edges
  wire sys_rst = ~rst_sync_r;

  // ==========================================================
  // Registers and state
  dcbh_state_t   state_r, state_nxt;
  logic          en_r;
  logic          armed_r, armed_nxt;
  logic          released_r;
  logic [15:0]   count_r;
  logic          sel_r, sel_nxt;
  logic          secondary_reset_out_r, secondary_reset_out_nxt;
  logic          wait_r, wait_nxt;
  logic          pflt_r, pflt_nxt;
  logic          sflt_r, sflt_nxt;
  dcbh_sys_bus_t sys_r, sys_nxt;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;

  // ==========================================================
  // Trigger decode
  // port 38H write seen from the primary
  wire pri_port_wr = ~pri_bus.io_request_strobe_n & ~pri_bus.wr_n &
                     (pri_bus.addr[7:0] == DCBH_PRI_PORT);
  // store to A038H seen from the secondary
  wire sec_store   = sec_bus.mem_en & ~sec_bus.rw &
                     (sec_bus.addr == DCBH_SEC_STORE);
  wire pri_go      = en_r & armed_r & ~pri_halt_n;
  wire sec_go      = en_r & sec_store;

  // ==========================================================
  // Handover sequencing
  always_comb begin
    state_nxt = state_r;
    armed_nxt = armed_r | pri_port_wr;
    sel_nxt   = sel_r;
    secondary_reset_out_nxt  = secondary_reset_out_r;
    wait_nxt  = wait_r;
    pflt_nxt  = pflt_r;
    sflt_nxt  = sflt_r;
    unique case (state_r)
      ST_PRI: begin
        if (pri_go) begin
          pflt_nxt  = 1'b1;
          state_nxt = ST_PRI_FLT;
        end
      end
      ST_PRI_FLT: begin
        // select moves one cycle after float
        sel_nxt   = 1'b0;
        secondary_reset_out_nxt  = 1'b0;
        sflt_nxt  = 1'b0;
        // Set wins over the clear in this cycle
        armed_nxt = pri_port_wr;
        state_nxt = ST_SEC;
      end
      ST_SEC: begin
        // wait drops after select is low
        wait_nxt = 1'b0;
        if (sec_go && !wait_r) begin
          wait_nxt  = 1'b1;
          sflt_nxt  = 1'b1;
          state_nxt = ST_SEC_FLT;
        end
      end
      ST_SEC_FLT: begin
        sel_nxt   = 1'b1;
        pflt_nxt  = 1'b0;
        state_nxt = ST_PRI;
      end
    endcase
  end

  // ==========================================================
  // Shared bus selection
  // only the unfloated owner drives
  // Registered copy, so the bus trails the state by one cycle;
  // the float cycle between owners absorbs that lag
  wire pri_drv = (state_r == ST_PRI) & ~pflt_r;
  wire sec_drv = (state_r == ST_SEC) & ~sflt_r & ~wait_r;

  always_comb begin
    sys_nxt = DCBH_SYS_IDLE;
    if (pri_drv) begin
      sys_nxt.bus = pri_bus;
      sys_nxt.oe  = 1'b1;
    end else if (sec_drv) begin
      sys_nxt.bus = map_sec(sec_bus);
      sys_nxt.oe  = 1'b1;
    end
  end

  // reset forces the primary to own the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_PRI;
      armed_r <= 1'b0;
      sel_r   <= 1'b1;
      secondary_reset_out_r  <= 1'b1;
      wait_r  <= 1'b0;
      pflt_r  <= 1'b0;
      sflt_r  <= 1'b1;
      sys_r   <= DCBH_SYS_IDLE;
    end else if (sys_rst) begin
      state_r <= ST_PRI;
      armed_r <= 1'b0;
      sel_r   <= 1'b1;
      secondary_reset_out_r  <= 1'b1;
      wait_r  <= 1'b0;
      pflt_r  <= 1'b0;
      sflt_r  <= 1'b1;
      sys_r   <= DCBH_SYS_IDLE;
    end else begin
      state_r <= state_nxt;
      armed_r <= armed_nxt;
      sel_r   <= sel_nxt;
      secondary_reset_out_r  <= secondary_reset_out_nxt;
      wait_r  <= wait_nxt;
      pflt_r  <= pflt_nxt;
      sflt_r  <= sflt_nxt;
      sys_r   <= sys_nxt;
    end
  end

  // Survives pin reset so software can see a handover happened
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      released_r <= 1'b0;
      count_r    <= 16'h0000;
    end else if (state_r == ST_PRI_FLT) begin
      released_r <= 1'b1;
      count_r    <= count_r + 16'h0001;
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  wire setup   = psel & ~penable;
  wire hit_ctl = (paddr == DCBH_CTRL_ADDR);
  wire hit_st  = (paddr == DCBH_STATUS_ADDR);
  wire hit_cnt = (paddr == DCBH_COUNT_ADDR);
  wire mapped  = hit_ctl | hit_st | hit_cnt;
  wire wr_ctl  = psel & penable & pwrite & hit_ctl;

  wire [31:0] status_w = {25'h0000000, released_r, armed_r, sflt_r,
                          pflt_r, wait_r, secondary_reset_out_r, sel_r};
  wire [31:0] rd_mux   = hit_ctl ? {31'h00000000, en_r} :
                         hit_st  ? status_w :
                         hit_cnt ? {16'h0000, count_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r      <= DCBH_CTRL_RST;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        en_r <= pwdata[DCBH_CTRL_EN_BIT];
      end
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================
  // Outputs
  // owner indication
  assign core_select         = sel_r;
  assign secondary_reset_out = secondary_reset_out_r;
  assign secondary_wait      = wait_r;
  assign pri_float           = pflt_r;
  assign sec_float           = sflt_r;
  assign sys_bus             = sys_r;
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;

  // ==========================================================
  // Assertions
  // Bus properties see the registered copy, one cycle behind the state
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sel_owner_a: assert property (
    sys_r.oe |-> (sel_r == $past(state_r == ST_PRI)))
    else $error("core_select disagrees with bus owner");

  one_driver_a: assert property (
    !(!pflt_r && !sflt_r))
    else $error("both cores unfloated");

  pri_copy_a: assert property (
    pri_drv && !sys_rst |=> sys_r.bus.addr == $past(pri_bus.addr) && sys_r.oe)
    else $error("primary address not copied");

  sec_memory_request_strobe_a: assert property (
    sec_drv && !sys_rst |=> sys_r.bus.memory_request_strobe_n == !$past(sec_bus.mem_en) &&
                            sys_r.bus.io_request_strobe_n == !$past(sec_bus.io_en))
    else $error("secondary strobe polarity wrong");

  sec_rdwr_a: assert property (
    sec_drv && !sys_rst |=> sys_r.bus.rd_n == !$past(sec_bus.out_drive) &&
                            sys_r.bus.wr_n == $past(sec_bus.rw))
    else $error("secondary read or write mapping wrong");

  reset_hold_a: assert property (
    sys_rst |=> sel_r && secondary_reset_out_r && !sys_r.oe)
    else $error("reset did not force primary owner");

  hand_sec_a: assert property (
    state_r == ST_PRI && pri_go && !sys_rst |=> pflt_r && sel_r ##1 !sel_r && !secondary_reset_out_r)
    else $error("handover to secondary out of order");

  stop_sec_a: assert property (
    state_r == ST_SEC && sec_go && !wait_r && !sys_rst |=> wait_r && sflt_r ##1 sel_r)
    else $error("secondary not stopped on return store");

  resume_pri_a: assert property (
    $rose(sel_r) && !sys_rst |-> sflt_r && !pflt_r && state_r == ST_PRI)
    else $error("primary did not resume cleanly");

  wait_drop_a: assert property (
    $fell(sel_r) && wait_r |=> !wait_r || sys_rst)
    else $error("secondary wait not released");

  sel_after_flt_a: assert property (
    $changed(sel_r) && !$past(sys_rst) |-> $past(sel_r ? pflt_r : sflt_r))
    else $error("select changed before bus floated");

  bus_idle_a: assert property (
    $changed(sel_r) |-> !sys_r.oe)
    else $error("shared bus driven while owner changes");

  pri_float_a: assert property (
    !sel_r |-> pflt_r)
    else $error("primary bus not floated for secondary owner");

  sec_float_a: assert property (
    sel_r |-> sflt_r)
    else $error("secondary bus not floated for primary owner");

  sec_rst_a: assert property (
    !sel_r |-> !secondary_reset_out_r)
    else $error("secondary held in reset while owner");

  wait_owner_a: assert property (
    sel_r && !secondary_reset_out_r |-> wait_r)
    else $error("returned secondary not held by wait");

  halt_unarmed_a: assert property (
    state_r == ST_PRI && !armed_r |=> state_r != ST_PRI_FLT)
    else $error("handover without port write");

  first_hand_c: cover property (state_r == ST_PRI_FLT && !released_r);
  round_trip_c: cover property (state_r == ST_SEC_FLT ##1 state_r == ST_PRI);
  later_hand_c: cover property ($fell(sel_r) && wait_r);
  apb_err_c:    cover property (pslverr_r && pready_r);
  sec_stop_c:   cover property (state_r == ST_SEC_FLT && wait_r && sflt_r);

endmodule // dcbh_top

// ==== dcbh_cores_model.sv ====
// Behavioural model of the primary and secondary cores
`timescale 1ns/1ps

module dcbh_cores_model
  import dcbh_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Bench commands
  input  wire logic          go_pri,
  input  wire logic          go_sec,
  input  wire dcbh_pri_bus_t pri_cmd,
  input  wire dcbh_sec_bus_t sec_cmd,
  // Arbiter status
  input  wire logic          pri_float,
  input  wire logic          sec_float,
  input  wire logic          secondary_reset_out,
  input  wire logic          secondary_wait,
  // Core buses
  output dcbh_pri_bus_t      pri_bus,
  output logic               pri_halt_n,
  output dcbh_sec_bus_t      sec_bus
);
  logic [1:0] ph_r;
  wire logic  sec_off = sec_float | secondary_reset_out | secondary_wait;

  // ====
  // Primary core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_r       <= 2'h0;
      pri_halt_n <= 1'h1;
      pri_bus    <= DCBH_SYS_IDLE.bus;
    end else if (pri_float) begin
      pri_bus <= '{~pri_bus.addr, ~pri_bus.data, 1'h1, 1'h1, 1'h1, 1'h1};
      ph_r    <= 2'h3;
    end else if (ph_r == 2'h3) begin
      ph_r       <= 2'h0;
      pri_halt_n <= 1'h1;
    end else if (ph_r == 2'h0 && go_pri) begin
      pri_bus <= '{{8'h00, DCBH_PRI_PORT}, 8'h5C, 1'h1, 1'h0, 1'h1, 1'h0};
      ph_r    <= 2'h1;
    end else if (ph_r == 2'h1) begin
      pri_bus    <= DCBH_SYS_IDLE.bus;
      pri_halt_n <= 1'h0;
      ph_r       <= 2'h2;
    end else if (ph_r == 2'h0) begin
      pri_bus <= pri_cmd;
    end
  end

  // ====
  // Secondary core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_bus <= '0;
    end else if (sec_off) begin
      sec_bus <= '{~sec_bus.addr, ~sec_bus.data, 1'h0, 1'h0, 1'h0, 1'h1};
    end else if (go_sec) begin
      sec_bus <= '{DCBH_SEC_STORE, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0};
    end else begin
      sec_bus <= sec_cmd;
    end
  end
endmodule // dcbh_cores_model

// ==== dcbh_tb_top.sv ====
// Self-checking bench for the bus handover arbiter
`timescale 1ns/1ps

module dcbh_tb_top
  import dcbh_pkg::*;
;
  logic          pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0, prdata, rd;
  logic          pready, pslverr, er, system_reset_in = 1'h1, go_pri = 1'h0, go_sec = 1'h0;
  logic          pri_halt_n, pri_float, sec_float, secondary_reset_out, secondary_wait, core_select;
  dcbh_pri_bus_t pri_cmd = DCBH_SYS_IDLE.bus, pri_bus;
  dcbh_sec_bus_t sec_cmd = '0, sec_bus;
  dcbh_sys_bus_t sys_bus;
  dcbh_sec_bus_t s_in [4];
  dcbh_pri_bus_t s_ex [4];
  int            error_cnt = 0, n_compared = 0, cyc = 0;

  always #12.5 pclk = ~pclk;

  dcbh_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .system_reset_in(system_reset_in), .pri_bus(pri_bus), .pri_halt_n(pri_halt_n),
    .pri_float(pri_float), .sec_bus(sec_bus), .sec_float(sec_float),
    .secondary_reset_out(secondary_reset_out), .secondary_wait(secondary_wait),
    .sys_bus(sys_bus), .core_select(core_select));

  dcbh_cores_model cores (.pclk(pclk), .presetn(presetn), .go_pri(go_pri), .go_sec(go_sec),
    .pri_cmd(pri_cmd), .sec_cmd(sec_cmd), .pri_float(pri_float), .sec_float(sec_float),
    .secondary_reset_out(secondary_reset_out), .secondary_wait(secondary_wait),
    .pri_bus(pri_bus), .pri_halt_n(pri_halt_n), .sec_bus(sec_bus));

  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ====
  // APB master, waits on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    cmp(32'(pready), 1, "no ready");
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic apb_rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'h0, a, 32'h0);
    cmp(rd, exp, "read data");
    cmp(32'(er), 32'(e), "error response");
  endtask

  task automatic wait_sel(input logic v);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (core_select !== v && k < 40);
    cmp(32'(core_select), 32'(v), "handover timed out");
  endtask

  // Owner never shares the bus with the other core
  always @(posedge pclk) begin
    cyc++;
    if (presetn) cmp(32'(core_select ? sec_float : pri_float), 1, "both cores drive");
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] %0t run hung", $time);
      report_and_stop;
    end
  end

  initial begin
    s_in = '{'{16'h1234, 8'h5A, 1'h1, 1'h0, 1'h1, 1'h1}, '{16'hABCD, 8'hC3, 1'h1, 1'h0, 1'h0, 1'h0},
             '{16'h8001, 8'h81, 1'h0, 1'h1, 1'h1, 1'h1}, '{16'h7FFE, 8'h7E, 1'h0, 1'h1, 1'h0, 1'h0}};
    s_ex = '{'{16'h1234, 8'h5A, 1'h0, 1'h1, 1'h0, 1'h1}, '{16'hABCD, 8'hC3, 1'h0, 1'h1, 1'h1, 1'h0},
             '{16'h8001, 8'h81, 1'h1, 1'h0, 1'h0, 1'h1}, '{16'h7FFE, 8'h7E, 1'h1, 1'h0, 1'h1, 1'h0}};
    tick(10);
    presetn <= 1'h1;
    @(posedge pclk);
    cmp(32'({core_select, secondary_reset_out}), 32'h3, "reset owner");
    apb_rd(DCBH_STATUS_ADDR, 32'h13, 1'h0);
    apb_rd(DCBH_CTRL_ADDR, 32'h1, 1'h0);
    apb_rd(8'h0C, 32'h0, 1'h1);
    pri_cmd <= '{16'h5AA5, 8'h3C, 1'h0, 1'h1, 1'h0, 1'h1};
    tick(3);
    cmp(32'(sys_bus), 32'({pri_cmd, 1'h1}), "primary copy");
    go_pri <= 1'h1;
    wait_sel(1'h0);
    cmp(32'({pri_float, secondary_reset_out}), 32'h2, "first handover");
    go_pri <= 1'h0;
    tick(3);
    for (int i = 0; i < 4; i++) begin
      sec_cmd <= s_in[i];
      tick(3);
      cmp(32'(sys_bus), 32'({s_ex[i], 1'h1}), "secondary strobe map");
    end
    go_sec <= 1'h1;
    wait_sel(1'h1);
    cmp(32'({secondary_wait, sec_float}), 32'h3, "secondary not stopped");
    go_sec <= 1'h0;
    tick(3);
    cmp(32'(sys_bus), 32'({pri_cmd, 1'h1}), "primary not resumed");
    go_pri <= 1'h1;
    wait_sel(1'h0);
    cmp(32'(secondary_wait), 1, "wait dropped early");
    tick(1);
    cmp(32'(secondary_wait), 0, "secondary not resumed");
    go_pri <= 1'h0;
    apb_rd(DCBH_COUNT_ADDR, 32'h2, 1'h0);
    apb_rd(DCBH_STATUS_ADDR, 32'h48, 1'h0);
    // Disabled arbiter must ignore the return store
    apb(1'h1, DCBH_CTRL_ADDR, 32'h0);
    go_sec <= 1'h1;
    tick(8);
    cmp(32'(core_select), 0, "disabled return taken");
    system_reset_in <= 1'h0;
    tick(6);
    cmp(32'({core_select, secondary_reset_out, secondary_wait, sec_float, pri_float}), 32'h1A, "pin reset");
    system_reset_in <= 1'h1;
    go_sec <= 1'h0;
    apb_rd(DCBH_CTRL_ADDR, 32'h0, 1'h0);
    report_and_stop;
  end
endmodule // dcbh_tb_top
